/* port_b_pkg.sv */
// Constants and types shared by the port B alternate function override block
// Notes on behaviour
// RL1 - Pin-change events fire on enabled, unmasked pins, even when driven as outputs.
// RL2 - Pin 7 is the active-low reset input only while the reset disable fuse reads 1.
// RL3 - As reset, pin 7 has pull-up forced on, driver off, digital input off.
// RL4 - Pin-change on pin 7 is masked while it is the reset input.
// RL5 - Digital input stays on in sleep when the pin's pin-change is enabled and unmasked.
// RL6 - Pin-change needs global enable, group enable and no masking alternate use.
// RL7 - Pin 6 feeds external interrupt 0 when its enable bit is set.
// RL8 - Pin 6 feeds timer0 count clock when clock select bits 2 and 1 are set.
// RL9 - Pin-change on pin 6 masked by low-level interrupt 0 or timer0 count use.
// RL10 - Pin 5 is oscillator output except for RC, external or PLL clock; then masked.
// RL11 - Pin 4 is oscillator input except for RC or PLL clock; then masked.
// RL12 - Pin 3 carries timer1 compare B output only when its direction bit is set.
// RL13 - Pin-change on pin 3 masked while timer1 compare B drives it.
// RL14 - Pin 2 is clock input when programming; in three-wire mode direction bit decides.
// RL15 - Two-wire mode pulls pin 2 low on zero output bit or start while its direction bit is set; no pull-up.
// RL16 - Pin 2 outputs inverted timer1 B only with serial unit off and direction set.
// RL17 - Pin-change on pin 2 masked by inverted timer1 B or serial clock use.
// RL18 - Three-wire mode drives serial data out on pin 1 when its direction is set and not programming.
// RL19 - In three-wire mode pin 1 output bit still enables pull-up when input.
// RL20 - Pin 1 carries timer1 compare A when direction set and not programming or serial.
// RL21 - Pin-change on pin 1 masked by timer1 compare A or three-wire data output.
// RL22 - Software should set analog input pins as inputs with pull-ups off.
// RL23 - Input enables and pin-change qualification derive from current enables and fuses.
package port_b_pkg;
	// Pin vector covers pins 7 down to 1
	typedef logic [7:1] pins_t;
	// Pin roles
	localparam int RST_PIN     = 7;
	localparam int IRQ_PIN     = 6;
	localparam int OSC_OUT_PIN = 5;
	localparam int OSC_IN_PIN  = 4;
	localparam int OCB_PIN     = 3;
	localparam int SCK_PIN     = 2;
	localparam int DO_PIN      = 1;
	// Pin-change group membership
	localparam pins_t GROUP_HI_MASK = 7'h78;
	localparam pins_t GROUP_LO_MASK = 7'h07;
	// Reset values
	localparam pins_t PINS_RST     = 7'h00;
	localparam logic  RST_PIN_IDLE = 1'h1;
	// Chip clock source selected by fuses
	typedef enum logic [1:0] {CLK_RC_OSC, CLK_EXT_CLOCK, CLK_PLL, CLK_CRYSTAL} clk_src_t;
	// Universal serial unit wire mode
	typedef enum logic [1:0] {USI_OFF, USI_THREE_WIRE, USI_TWO_WIRE} usi_mode_t;
	// Registered state of the override core
	typedef struct packed {
		pins_t drv_val;
		pins_t drv_en;
		pins_t pull_en;
		pins_t die;
		pins_t in_val;
		logic  rst_n;
		logic  irq0_pin;
		logic  t0_clk;
	} core_st_t;
	localparam core_st_t CORE_ST_RST = '{PINS_RST, PINS_RST, PINS_RST, PINS_RST,
		PINS_RST, RST_PIN_IDLE, RST_PIN_IDLE, 1'h0};
endpackage

/* pc_if.sv */
// Interface between the override core and the pin-change detector
`timescale 1ns/1ps
interface pc_if import port_b_pkg::*; ();
	pins_t pin_val;   // Synchronised pin levels
	pins_t qualify;   // Pin-change allowed per pin
	pins_t evt_pulse; // One-cycle change events
	logic  irq_hi;    // High group pulse
	logic  irq_lo;    // Low group pulse
	modport core (
		output pin_val,
		output qualify,
		input  evt_pulse,
		input  irq_hi,
		input  irq_lo
	);
	modport detect (
		input  pin_val,
		input  qualify,
		output evt_pulse,
		output irq_hi,
		output irq_lo
	);
endinterface // pc_if

/* pin_sync.sv */
// Two-stage synchroniser for the port B pin levels
`timescale 1ns/1ps
module pin_sync
	import port_b_pkg::*;
(
	// Clock and reset
	input  wire logic  ref_clk_in,
	input  wire logic  arst_n_in,
	// Pins and synchronised levels
	input  wire pins_t pin_in,
	output pins_t      pin_sync_out
);
	typedef struct packed {
		pins_t s1;
		pins_t s2;
	} sync_st_t;
	sync_st_t st_r;
	sync_st_t st_nxt;

	// First stage feeds only the second
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
	end

	// Register the stages
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= {PINS_RST, PINS_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_sync_out = st_r.s2;
endmodule // pin_sync

/* pin_change_detect.sv */
// Pin-change event detector with group interrupt pulses
`timescale 1ns/1ps
module pin_change_detect
	import port_b_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic arst_n_in,
	// Link to the override core
	pc_if.detect      pc
);
	typedef struct packed {
		logic  armed;
		pins_t prev;
		pins_t evt;
		logic  irq_hi;
		logic  irq_lo;
	} det_st_t;
	det_st_t st_r;
	det_st_t st_nxt;

	// Compare against last level; the first cycle only loads it
	always_comb begin
		st_nxt        = st_r;
		st_nxt.armed  = 1'h1;
		st_nxt.prev   = pc.pin_val;
		st_nxt.evt    = st_r.armed ? ((pc.pin_val ^ st_r.prev) & pc.qualify)
			: PINS_RST; // see RL1
		st_nxt.irq_hi = |(st_nxt.evt & GROUP_HI_MASK);
		st_nxt.irq_lo = |(st_nxt.evt & GROUP_LO_MASK);
	end

	// Register the detector state
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= {1'h0, PINS_RST, PINS_RST, 1'h0, 1'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pc.evt_pulse = st_r.evt;
	assign pc.irq_hi    = st_r.irq_hi;
	assign pc.irq_lo    = st_r.irq_lo;
endmodule // pin_change_detect

/* port_b_alt_function_override.sv */
// Alternate function override logic for port B pins 7 down to 1
`timescale 1ns/1ps
module port_b_alt_function_override
	import port_b_pkg::*;
(
	// Clock and reset
	input  wire logic      ref_clk_in,
	input  wire logic      arst_n_in,
	// Physical pins
	input  wire pins_t     pin_in,
	output pins_t          pin_drive_val_out,
	output pins_t          pin_drive_en_out,
	output pins_t          pull_up_en_out,
	// Software port bits
	input  wire pins_t     out_bits_in,
	input  wire pins_t     dir_bits_in,
	// Interrupt enables
	input  wire logic      global_irq_en_in,
	input  wire logic      pin_change_group_hi_en_in,
	input  wire logic      pin_change_group_lo_en_in,
	input  wire logic      ext_irq0_en_in,
	// Power and fuses
	input  wire logic      sleep_in,
	input  wire logic      reset_disable_fuse_in,
	input  wire clk_src_t  clock_source_in,
	// Timer controls and outputs
	input  wire logic      timer0_clock_select_bit2_in,
	input  wire logic      timer0_clock_select_bit1_in,
	input  wire logic      timer1_compare_out_a_en_in,
	input  wire logic      timer1_compare_out_a_in,
	input  wire logic      timer1_compare_out_b_en_in,
	input  wire logic      timer1_compare_out_b_in,
	input  wire logic      timer1_pwm_b_inv_en_in,
	input  wire logic      timer1_pwm_b_inv_in,
	// Serial unit and programming
	input  wire usi_mode_t usi_mode_in,
	input  wire logic      usi_data_out_in,
	input  wire logic      usi_start_detect_in,
	input  wire logic      spi_prog_en_in,
	// Digital input side
	output pins_t          dig_in_en_out,
	output pins_t          pin_in_val_out,
	output logic           reset_pin_n_out,
	output logic           ext_irq0_pin_out,
	output logic           timer0_ext_count_out,
	// Pin-change events
	output pins_t          pin_change_evt_out,
	output logic           pin_change_group_hi_irq_out,
	output logic           pin_change_group_lo_irq_out
);
	// ==========================================================
	// Decode helpers
	// ==========================================================

	// Pin-change allowed for a pin in a given group
	function automatic logic pc_qualify(input logic gie, input logic grp,
		input logic masked);
		pc_qualify = gie & grp & ~masked; // see RL6
	endfunction

	// Digital input stays on in sleep when pin-change is live
	function automatic logic die_normal(input logic slp, input logic pcq);
		die_normal = ~slp | pcq; // see RL5
	endfunction

	// ==========================================================
	// Signals
	// ==========================================================
	core_st_t st_r;
	core_st_t st_nxt;
	pins_t    pin_s;
	pins_t    pc_mask;
	pins_t    pc_q;
	logic     reset_pin_en;
	logic     ext_irq0_low_act;
	logic     ext_irq0_route;
	logic     t0_ext;
	logic     p5_io_en;
	logic     p4_io_en;
	logic     ext_clk_en;
	logic     usi_3w;
	logic     usi_2w;
	logic     usi_on;
	logic     ocb_on;
	logic     ocb_inv_on;
	logic     sck_use;
	logic     do_on;
	logic     oca_on;

	pc_if pc ();

	// ==========================================================
	// Pin synchroniser
	// ==========================================================

	// Pins are asynchronous and pass two flops first
	pin_sync u_sync (
		.ref_clk_in   (ref_clk_in),
		.arst_n_in    (arst_n_in),
		.pin_in       (pin_in),
		.pin_sync_out (pin_s)
	);

	// ==========================================================
	// Alternate function activity
	// ==========================================================

	// Reset pin role follows the fuse level directly
	assign reset_pin_en = reset_disable_fuse_in; // see RL2

	// External interrupt 0 routing and its low-level sensing
	assign ext_irq0_route   = ext_irq0_en_in; // see RL7
	assign ext_irq0_low_act = global_irq_en_in & ext_irq0_en_in;

	// Timer0 counts pin edges when both select bits are high
	assign t0_ext = timer0_clock_select_bit2_in &
		timer0_clock_select_bit1_in; // see RL8

	// Oscillator pins are free I/O only for some clock sources
	assign p5_io_en   = (clock_source_in == CLK_RC_OSC) ||
		(clock_source_in == CLK_EXT_CLOCK) ||
		(clock_source_in == CLK_PLL); // see RL10
	assign p4_io_en   = (clock_source_in == CLK_RC_OSC) ||
		(clock_source_in == CLK_PLL); // see RL11
	assign ext_clk_en = (clock_source_in == CLK_EXT_CLOCK);

	// Serial unit modes; an unused code counts as off
	assign usi_3w = (usi_mode_in == USI_THREE_WIRE);
	assign usi_2w = (usi_mode_in == USI_TWO_WIRE);
	assign usi_on = usi_3w | usi_2w;

	// Timer1 B on pin 3 needs the direction bit set
	assign ocb_on = timer1_compare_out_b_en_in & dir_bits_in[OCB_PIN]; // see RL12

	// Inverted timer1 B on pin 2 yields to serial use and programming
	assign ocb_inv_on = timer1_pwm_b_inv_en_in & ~usi_on & ~spi_prog_en_in &
		dir_bits_in[SCK_PIN]; // see RL16

	// Serial clock occupies pin 2 in any serial or programming mode
	assign sck_use = usi_on | spi_prog_en_in;

	// Three-wire data out takes pin 1 when set as output and not programming
	assign do_on = usi_3w & ~spi_prog_en_in & dir_bits_in[DO_PIN]; // see RL18

	// Timer1 A on pin 1 yields to programming and serial use
	assign oca_on = timer1_compare_out_a_en_in & ~spi_prog_en_in & ~usi_on &
		dir_bits_in[DO_PIN]; // see RL20

	// ==========================================================
	// Pin-change masking and qualification
	// ==========================================================

	// Alternate uses that mask pin-change per pin
	assign pc_mask[RST_PIN]     = reset_pin_en; // see RL4
	assign pc_mask[IRQ_PIN]     = ext_irq0_low_act | t0_ext; // see RL9
	assign pc_mask[OSC_OUT_PIN] = ~p5_io_en; // see RL10
	assign pc_mask[OSC_IN_PIN]  = ~p4_io_en; // see RL11
	assign pc_mask[OCB_PIN]     = ocb_on; // see RL13
	assign pc_mask[SCK_PIN]     = ocb_inv_on | sck_use; // see RL17
	assign pc_mask[DO_PIN]      = oca_on | do_on; // see RL21

	// Combine enables per group; computed from live inputs
	genvar gi;
	generate
		for (gi = 1; gi <= 7; gi++) begin : g_qual
			assign pc_q[gi] = pc_qualify(global_irq_en_in,
				GROUP_HI_MASK[gi] ? pin_change_group_hi_en_in
					: pin_change_group_lo_en_in,
				pc_mask[gi]); // see RL23
		end
	endgenerate

	// Detector link
	assign pc.pin_val = pin_s;
	assign pc.qualify = pc_q;

	// Pin-change event detector
	pin_change_detect u_detect (
		.ref_clk_in (ref_clk_in),
		.arst_n_in  (arst_n_in),
		.pc         (pc.detect)
	);

	// ==========================================================
	// Override next state
	// ==========================================================
	always_comb begin
		st_nxt = st_r;

		// Ordinary port behaviour on all pins first
		st_nxt.drv_en  = dir_bits_in;
		st_nxt.drv_val = out_bits_in;
		st_nxt.pull_en = ~dir_bits_in & out_bits_in;
		for (int i = 1; i <= 7; i++) begin
			st_nxt.die[i] = die_normal(sleep_in, pc_q[i]); // see RL5
		end

		// Pin 7: reset input takes pull-up, driver and input
		if (reset_pin_en) begin
			st_nxt.pull_en[RST_PIN] = 1'h1; // see RL3
			st_nxt.drv_en[RST_PIN]  = 1'h0;
			st_nxt.drv_val[RST_PIN] = 1'h0;
			st_nxt.die[RST_PIN]     = 1'h0; // see RL3
		end

		// Pin 6: interrupt or counter needs the input path live
		if (ext_irq0_route || t0_ext) begin
			st_nxt.die[IRQ_PIN] = 1'h1;
		end

		// Pin 5: oscillator output gives up all I/O use
		if (!p5_io_en) begin
			st_nxt.pull_en[OSC_OUT_PIN] = 1'h0; // see RL10
			st_nxt.drv_en[OSC_OUT_PIN]  = 1'h0;
			st_nxt.drv_val[OSC_OUT_PIN] = 1'h0;
			st_nxt.die[OSC_OUT_PIN]     = 1'h0;
		end

		// Pin 4: oscillator input; an external clock keeps the input path
		if (!p4_io_en) begin
			st_nxt.pull_en[OSC_IN_PIN] = 1'h0; // see RL11
			st_nxt.drv_en[OSC_IN_PIN]  = 1'h0;
			st_nxt.drv_val[OSC_IN_PIN] = 1'h0;
			st_nxt.die[OSC_IN_PIN]     = ext_clk_en;
		end

		// Pin 3: timer1 compare B replaces the port value
		if (ocb_on) begin
			st_nxt.drv_val[OCB_PIN] = timer1_compare_out_b_in; // see RL12
		end

		// Pin 2: programming, then serial modes, then inverted timer1 B
		if (spi_prog_en_in) begin
			st_nxt.drv_en[SCK_PIN]  = 1'h0; // see RL14
			st_nxt.drv_val[SCK_PIN] = 1'h0;
			st_nxt.pull_en[SCK_PIN] = 1'h0;
		end else if (usi_2w) begin
			// Open collector: only ever pulls low
			st_nxt.drv_en[SCK_PIN]  = dir_bits_in[SCK_PIN] &
				(~out_bits_in[SCK_PIN] | usi_start_detect_in); // see RL15
			st_nxt.drv_val[SCK_PIN] = 1'h0;
			st_nxt.pull_en[SCK_PIN] = 1'h0; // see RL15
		end else if (usi_3w) begin
			// Master drives, slave listens, per the direction bit
			st_nxt.drv_en[SCK_PIN] = dir_bits_in[SCK_PIN]; // see RL14
		end else if (ocb_inv_on) begin
			st_nxt.drv_val[SCK_PIN] = timer1_pwm_b_inv_in; // see RL16
		end

		// Pin 1: data out replaces the value, output bit keeps the pull-up
		if (do_on) begin
			st_nxt.drv_val[DO_PIN] = usi_data_out_in; // see RL18
		end else if (oca_on) begin
			st_nxt.drv_val[DO_PIN] = timer1_compare_out_a_in; // see RL20
		end
		if (usi_3w) begin
			st_nxt.pull_en[DO_PIN] = ~dir_bits_in[DO_PIN] &
				out_bits_in[DO_PIN]; // see RL19
		end

		// Input levels gated by the digital input enable
		st_nxt.in_val = pin_s & st_nxt.die;

		// Reset pin level reaches reset logic only in its reset role
		st_nxt.rst_n = reset_pin_en ? pin_s[RST_PIN] : RST_PIN_IDLE; // see RL2

		// Pin 6 feeds interrupt 0 and timer0 when routed
		st_nxt.irq0_pin = ext_irq0_route ? pin_s[IRQ_PIN] : RST_PIN_IDLE; // see RL7
		st_nxt.t0_clk   = t0_ext & pin_s[IRQ_PIN]; // see RL8
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= CORE_ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================

	// Pin drive and pull-up
	assign pin_drive_val_out = st_r.drv_val;
	assign pin_drive_en_out  = st_r.drv_en;
	assign pull_up_en_out    = st_r.pull_en;

	// Digital input side
	assign dig_in_en_out        = st_r.die;
	assign pin_in_val_out       = st_r.in_val;
	assign reset_pin_n_out      = st_r.rst_n;
	assign ext_irq0_pin_out     = st_r.irq0_pin;
	assign timer0_ext_count_out = st_r.t0_clk;

	// Pin-change results come straight from detector flops
	assign pin_change_evt_out          = pc.evt_pulse; // see RL1
	assign pin_change_group_hi_irq_out = pc.irq_hi;
	assign pin_change_group_lo_irq_out = pc.irq_lo;
endmodule // port_b_alt_function_override

/* port_b_checker.sv */
// Assertion checker for the port B alternate function override block
`timescale 1ns/1ps
module port_b_checker
	import port_b_pkg::*;
(
	// Clock and reset
	input wire logic      ref_clk_in, arst_n_in,
	// Pin side outputs
	input wire pins_t     pin_drive_val_out, pin_drive_en_out, pull_up_en_out,
	input wire pins_t     dig_in_en_out, pin_change_evt_out,
	input wire logic      pin_change_group_hi_irq_out, pin_change_group_lo_irq_out,
	// Software bits and enables
	input wire pins_t     out_bits_in, dir_bits_in,
	input wire logic      global_irq_en_in, pin_change_group_hi_en_in,
	input wire logic      pin_change_group_lo_en_in, sleep_in, reset_disable_fuse_in,
	// Peripheral controls
	input wire logic      spi_prog_en_in, usi_data_out_in, usi_start_detect_in,
	input wire logic      timer1_compare_out_b_en_in, timer1_compare_out_b_in,
	input wire clk_src_t  clock_source_in,
	input wire usi_mode_t usi_mode_in
);
	logic [1:0] up_r;
	// Holds off $past until two live edges have passed
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			up_r <= 2'h0;
		else if (up_r != 2'h2)
			up_r <= up_r + 2'h1;
	end
	wire ok = (up_r == 2'h2);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// ==========================================================
	// Assertions
	a_rst_pin_role: assert property (ok && $past(reset_disable_fuse_in) |->
		pull_up_en_out[7] && !pin_drive_en_out[7] && !dig_in_en_out[7])
		else $error("reset pin role not applied");
	a_rst_pc_mask: assert property (ok && $past(reset_disable_fuse_in) |->
		!pin_change_evt_out[7]) else $error("pin 7 event while reset role");
	a_no_irq_gie: assert property (ok && !$past(global_irq_en_in) |->
		pin_change_evt_out == 7'h00) else $error("event without global enable");
	a_group_hi_or: assert property (pin_change_group_hi_irq_out ==
		|(pin_change_evt_out & GROUP_HI_MASK)) else $error("high group pulse wrong");
	a_group_lo_gate: assert property (ok && !$past(pin_change_group_lo_en_in) |->
		!pin_change_group_lo_irq_out) else $error("low group pulse while disabled");
	a_sleep_die_kept: assert property (ok && $past(sleep_in && global_irq_en_in &&
		pin_change_group_hi_en_in && clock_source_in == CLK_RC_OSC) |-> dig_in_en_out[5])
		else $error("pin 5 input off in sleep");
	a_osc_out_mask: assert property (ok && $past(clock_source_in == CLK_CRYSTAL) |->
		!pin_drive_en_out[5] && !pull_up_en_out[5] && !pin_change_evt_out[5])
		else $error("oscillator output pin used as port");
	a_ocb_drive: assert property (ok && $past(dir_bits_in[3] &&
		timer1_compare_out_b_en_in) |-> pin_drive_en_out[3] &&
		pin_drive_val_out[3] == $past(timer1_compare_out_b_in))
		else $error("compare B not on pin 3");
	a_two_wire_pull: assert property (ok && $past(usi_mode_in == USI_TWO_WIRE &&
		!spi_prog_en_in) |-> !pull_up_en_out[2] && !(pin_drive_en_out[2] && pin_drive_val_out[2])
		&& pin_drive_en_out[2] == $past(dir_bits_in[2] & (~out_bits_in[2] | usi_start_detect_in)))
		else $error("two-wire clock pin wrong");
	a_do_override: assert property (ok && $past(usi_mode_in == USI_THREE_WIRE &&
		!spi_prog_en_in && dir_bits_in[1]) |-> pin_drive_en_out[1] &&
		pin_drive_val_out[1] == $past(usi_data_out_in)) else $error("data out not on pin 1");
	// Main scenarios reached
	c_hi_event: cover property (pin_change_group_hi_irq_out);
	c_lo_event: cover property (pin_change_group_lo_irq_out);
	c_reset_role: cover property (pull_up_en_out[7] && !dig_in_en_out[7]);
endmodule // port_b_checker

bind port_b_alt_function_override port_b_checker u_port_b_checker (.*);

/* pin_board.sv */
// Model of the board and outside drivers around the port B pins
`timescale 1ns/1ps
module pin_board
	import port_b_pkg::*;
(
	// Clock
	input  wire logic  ref_clk_in,
	// Device and outside drivers
	input  wire pins_t drv_val_in, drv_en_in, pull_en_in, ext_val_in, ext_en_in,
	// Resolved pin levels
	output pins_t      pin_lvl_out
);
	pins_t last_r;
	// Device, then outside driver, then pull-up; a floating pin wanders
	assign pin_lvl_out = (drv_en_in & drv_val_in) | (~drv_en_in & ext_en_in & ext_val_in) |
		(~drv_en_in & ~ext_en_in & (pull_en_in | ~last_r));
	// Last level of each pin
	always_ff @(posedge ref_clk_in) last_r <= pin_lvl_out;
endmodule // pin_board

/* tb_port_b_alt_function_override.sv */
// Self-checking testbench for the port B alternate function override block
`timescale 1ns/1ps
module tb_port_b_alt_function_override;
	import port_b_pkg::*;
	logic ref_clk_in, arst_n_in, global_irq_en_in, pin_change_group_hi_en_in;
	logic pin_change_group_lo_en_in, ext_irq0_en_in, sleep_in, reset_disable_fuse_in;
	logic timer0_clock_select_bit2_in, timer0_clock_select_bit1_in, timer1_compare_out_a_en_in;
	logic timer1_compare_out_a_in, timer1_compare_out_b_en_in, timer1_compare_out_b_in;
	logic timer1_pwm_b_inv_en_in, timer1_pwm_b_inv_in, usi_data_out_in, usi_start_detect_in;
	logic spi_prog_en_in, clr, reset_pin_n_out, ext_irq0_pin_out, timer0_ext_count_out;
	logic pin_change_group_hi_irq_out, pin_change_group_lo_irq_out;
	pins_t pin_in, out_bits_in, dir_bits_in, ext_val, ext_en, seen, pin_drive_val_out;
	pins_t pin_drive_en_out, pull_up_en_out, dig_in_en_out, pin_in_val_out, pin_change_evt_out;
	clk_src_t clock_source_in;
	usi_mode_t usi_mode_in;
	int err_total, checked, cyc;
	// Design and board
	port_b_alt_function_override u_port_b_alt_function_override (.*);
	pin_board u_pin_board (.ref_clk_in(ref_clk_in), .drv_val_in(pin_drive_val_out),
		.drv_en_in(pin_drive_en_out), .pull_en_in(pull_up_en_out), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .pin_lvl_out(pin_in));
	// Clock, event collector and timeout
	initial begin
		ref_clk_in = 1'h0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) seen <= clr ? 7'h00 : (seen | pin_change_evt_out);
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			summarize;
		end
	end
	// ==========================================================
	// Helpers
	task automatic ck(input string n, input logic [6:0] e, input logic [6:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask
	// Toggles pins, port bits and peripheral values, then gathers events
	task automatic flip(input pins_t by_ext, input pins_t by_out, input logic tgl);
		@(posedge ref_clk_in);
		ext_val <= ext_val ^ by_ext;
		out_bits_in <= out_bits_in ^ by_out;
		{timer1_compare_out_a_in, timer1_compare_out_b_in, timer1_pwm_b_inv_in, usi_data_out_in}
			<= {4{tgl}} ^ {timer1_compare_out_a_in, timer1_compare_out_b_in,
			timer1_pwm_b_inv_in, usi_data_out_in};
		clr <= 1'h1;
		@(posedge ref_clk_in);
		clr <= 1'h0;
		tick(5);
	endtask
	// Vector holds prog, dir, out, start, then expected enable, value and pull-up
	task automatic p2(input usi_mode_t m, input logic [6:0] v);
		@(posedge ref_clk_in);
		{usi_mode_in, spi_prog_en_in, usi_start_detect_in} <= {m, v[6], v[3]};
		dir_bits_in <= {5'h00, v[5], 1'h0};
		out_bits_in <= {5'h00, v[4], 1'h0};
		tick(1);
		ck("p2 en", 7'(v[2]), 7'(pin_drive_en_out[2]));
		if (v[2])
			ck("p2 val", 7'(v[1]), 7'(pin_drive_val_out[2]));
		ck("p2 pull", 7'(v[0]), 7'(pull_up_en_out[2]));
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset_pin;
		@(posedge ref_clk_in);
		{reset_disable_fuse_in, global_irq_en_in, pin_change_group_hi_en_in} <= 3'h7;
		dir_bits_in <= 7'h40;
		flip(7'h40, 7'h00, 1'h0);
		ck("p7 pull", 7'h01, 7'(pull_up_en_out[7]));
		ck("p7 drv", 7'h00, 7'(pin_drive_en_out[7] | dig_in_en_out[7]));
		ck("p7 evt", 7'h00, seen & 7'h40);
		ck("rst lvl", 7'h00, 7'(reset_pin_n_out));
		reset_disable_fuse_in <= 1'h0;
		flip(7'h40, 7'h40, 1'h0);
		ck("rst idle", 7'h01, 7'(reset_pin_n_out));
		ck("p7 out evt", 7'h40, seen & 7'h40);
		dir_bits_in <= 7'h00;
		out_bits_in <= 7'h00;
	endtask
	task automatic t_change;
		@(posedge ref_clk_in);
		sleep_in <= 1'h1;
		tick(1);
		ck("sleep die", 7'h10, dig_in_en_out & 7'h14);
		flip(7'h10, 7'h00, 1'h0);
		ck("p5 evt", 7'h10, seen);
		global_irq_en_in <= 1'h0;
		flip(7'h10, 7'h00, 1'h0);
		ck("no gie", 7'h00, seen);
		{global_irq_en_in, pin_change_group_hi_en_in} <= 2'h2;
		flip(7'h10, 7'h00, 1'h0);
		ck("no grp", 7'h00, seen);
		{pin_change_group_hi_en_in, sleep_in} <= 2'h2;
	endtask
	task automatic t_osc;
		@(posedge ref_clk_in);
		clock_source_in <= CLK_CRYSTAL;
		{dir_bits_in, out_bits_in} <= {7'h18, 7'h18};
		flip(7'h18, 7'h00, 1'h0);
		ck("xtal drv", 7'h00, (pin_drive_en_out | pull_up_en_out | seen) & 7'h18);
		clock_source_in <= CLK_EXT_CLOCK;
		tick(1);
		ck("ext drv", 7'h10, pin_drive_en_out & 7'h18);
		clock_source_in <= CLK_PLL;
		flip(7'h00, 7'h18, 1'h0);
		ck("pll io", 7'h18, (pin_drive_en_out & seen) & 7'h18);
		{dir_bits_in, out_bits_in} <= '0;
		clock_source_in <= CLK_RC_OSC;
	endtask
	task automatic t_pin6;
		@(posedge ref_clk_in);
		ext_irq0_en_in <= 1'h1;
		flip(7'h20, 7'h00, 1'h0);
		ck("irq0 lvl", 7'h00, 7'(ext_irq0_pin_out));
		ck("irq0 evt", 7'h00, seen & 7'h20);
		{ext_irq0_en_in, timer0_clock_select_bit2_in, timer0_clock_select_bit1_in} <= 3'h3;
		flip(7'h20, 7'h00, 1'h0);
		ck("t0 lvl", 7'h01, 7'(timer0_ext_count_out));
		ck("p6 in", 7'h20, pin_in_val_out & 7'h20);
		ck("t0 evt", 7'h00, seen & 7'h20);
		timer0_clock_select_bit1_in <= 1'h0;
		tick(1);
		ck("t0 off", 7'h00, 7'(timer0_ext_count_out));
		timer0_clock_select_bit2_in <= 1'h0;
	endtask
	task automatic t_pin3;
		@(posedge ref_clk_in);
		{pin_change_group_lo_en_in, dir_bits_in} <= {1'h1, 7'h04};
		flip(7'h00, 7'h04, 1'h0);
		ck("p3 evt", 7'h04, seen & 7'h04);
		timer1_compare_out_b_en_in <= 1'h1;
		flip(7'h00, 7'h00, 1'h1);
		ck("ocb val", 7'(timer1_compare_out_b_in), 7'(pin_drive_val_out[3]));
		ck("ocb evt", 7'h00, seen & 7'h04);
		dir_bits_in <= 7'h00;
		tick(1);
		ck("ocb nodir", 7'h00, 7'(pin_drive_en_out[3]));
		timer1_compare_out_b_en_in <= 1'h0;
	endtask
	task automatic t_pin1;
		@(posedge ref_clk_in);
		{usi_mode_in, dir_bits_in, out_bits_in} <= {USI_THREE_WIRE, 7'h01, 7'h00};
		{spi_prog_en_in, timer1_pwm_b_inv_en_in} <= 2'h0;
		flip(7'h00, 7'h00, 1'h1);
		ck("do val", 7'(usi_data_out_in), 7'(pin_drive_val_out[1]));
		ck("do evt", 7'h00, seen & 7'h01);
		{dir_bits_in, out_bits_in} <= {7'h00, 7'h01};
		tick(1);
		ck("do pull", 7'h01, 7'(pull_up_en_out[1]));
		{usi_mode_in, dir_bits_in, out_bits_in} <= {USI_OFF, 7'h01, 7'h00};
		timer1_compare_out_a_en_in <= 1'h1;
		flip(7'h00, 7'h00, 1'h1);
		ck("oca val", 7'(timer1_compare_out_a_in), 7'(pin_drive_val_out[1]));
		ck("oca evt", 7'h00, seen & 7'h01);
		spi_prog_en_in <= 1'h1;
		out_bits_in <= {6'h00, ~timer1_compare_out_a_in};
		tick(1);
		ck("oca prog", 7'(out_bits_in[1]), 7'(pin_drive_val_out[1]));
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{arst_n_in, global_irq_en_in, pin_change_group_hi_en_in, pin_change_group_lo_en_in} = '0;
		{ext_irq0_en_in, sleep_in, reset_disable_fuse_in, spi_prog_en_in, clr} = '0;
		{timer0_clock_select_bit2_in, timer0_clock_select_bit1_in, usi_start_detect_in} = '0;
		{timer1_compare_out_a_en_in, timer1_compare_out_b_en_in, timer1_pwm_b_inv_en_in} = '0;
		{timer1_compare_out_a_in, timer1_compare_out_b_in, timer1_pwm_b_inv_in, usi_data_out_in} = '0;
		{out_bits_in, dir_bits_in} = '0;
		{ext_val, ext_en} = 14'h3fff;
		clock_source_in = CLK_RC_OSC;
		usi_mode_in = USI_OFF;
		tick(2);
		ck("rst outs", 7'h01, {pin_drive_en_out[7:2], reset_pin_n_out});
		@(posedge ref_clk_in);
		arst_n_in <= 1'h1;
		tick(2);
		t_reset_pin();
		t_change();
		t_osc();
		t_pin6();
		t_pin3();
		p2(USI_TWO_WIRE, 7'h24);
		p2(USI_TWO_WIRE, 7'h30);
		p2(USI_TWO_WIRE, 7'h3c);
		p2(USI_TWO_WIRE, 7'h10);
		p2(USI_THREE_WIRE, 7'h36);
		p2(USI_THREE_WIRE, 7'h11);
		p2(USI_THREE_WIRE, 7'h70);
		{timer1_pwm_b_inv_en_in, timer1_pwm_b_inv_in} <= 2'h3;
		p2(USI_OFF, 7'h26);
		p2(usi_mode_t'(2'h3), 7'h26);
		p2(USI_THREE_WIRE, 7'h24);
		p2(USI_OFF, 7'h00);
		p2(USI_OFF, 7'h26);
		flip(7'h00, 7'h00, 1'h1);
		ck("inv evt", 7'h00, seen & 7'h02);
		ck("inv val", 7'(timer1_pwm_b_inv_in), 7'(pin_drive_val_out[2]));
		t_pin1();
		summarize;
	end
endmodule // tb_port_b_alt_function_override
